// File: verification/urtc_core_asserts.sv
// concurrent port checks for the serial unit
`timescale 1ns/1ps
`default_nettype none
module urtc_core_asserts (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic clkRun, // clock supply
    input wire logic powerEnable, // power
    input wire logic transmitEnable, // tx enable
    input wire logic [3:0] baseClockSelect, // m
    input wire logic [7:0] baudDivisor, // k
    input wire logic txWrite, // data write
    input wire logic txReady, // write room
    input wire logic txBusy, // tx active
    input wire logic transmitLine, // serial out
    input wire logic receiveLine, // serial in
    input wire logic rxValid, // byte ready
    input wire logic parityError, // parity flag
    input wire logic framingError, // framing flag
    input wire logic errorClear // flag clear
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] lowCnt_q;
    // fixed figures below only hold for the fastest setting
    wire logic fastCfg = baudDivisor == 8'h04 && baseClockSelect == 4'h0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) lowCnt_q <= 8'h00;
        else if (receiveLine) lowCnt_q <= 8'h00;
        else if (lowCnt_q != 8'hFF) lowCnt_q <= lowCnt_q + 8'h01;
    end
    chk_ready_gate: assert property (txReady |-> clkRun && powerEnable && transmitEnable)
        else $error("write room while unit disabled");
    chk_write_busy: assert property (txWrite && txReady |=> txBusy)
        else $error("accepted write left unit idle");
    chk_start_soon: assert property (txWrite && txReady && !txBusy && fastCfg
        ##1 (clkRun && powerEnable && transmitEnable) |=> !transmitLine)
        else $error("no start bit after write");
    chk_start_width: assert property ($fell(transmitLine) && fastCfg
        |-> (!transmitLine || !transmitEnable || !powerEnable) [*8])
        else $error("start bit shorter than 2k ticks");
    chk_idle_high: assert property (!txBusy |-> transmitLine)
        else $error("line low with nothing to send");
    chk_disable_high: assert property (clkRun && !transmitEnable |=> transmitLine)
        else $error("line low while transmit disabled");
    chk_freeze_all: assert property (!clkRun |=> $stable(transmitLine) && $stable(txBusy)
        && $stable(rxValid) && $stable(parityError))
        else $error("state moved without clock supply");
    chk_flags_sticky: assert property (!errorClear |=> (parityError || !$past(parityError))
        && (framingError || !$past(framingError)))
        else $error("error flag lost without clear");
    chk_no_lowstart: assert property (lowCnt_q >= 8'h78 && fastCfg |-> !$rose(rxValid))
        else $error("byte delivered from a held low line");
    cover property ($rose(framingError));
    cover property ($rose(parityError));
    cover property (!clkRun && txBusy);
endmodule
bind urtc_core urtc_core_asserts urtc_core_asserts_i (.sys_clk, .rst_n, .clkRun, .powerEnable,
    .transmitEnable, .baseClockSelect, .baudDivisor, .txWrite, .txReady, .txBusy,
    .transmitLine, .receiveLine, .rxValid, .parityError, .framingError, .errorClear);
`default_nettype wire

// File: verification/urtc_core_tb.sv
// self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
module urtc_core_tb;
    import urtc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkRun = 1'b1;
    logic powerEnable = 1'b0;
    logic transmitEnable = 1'b0;
    logic receiveEnable = 1'b0;
    logic [3:0] baseClockSelect = 4'h0;
    logic [7:0] baudDivisor = 8'h04;
    logic [1:0] parityMode = 2'h0;
    urtc_byte_t txData = 8'h00;
    urtc_byte_t rxData;
    logic txWrite = 1'b0;
    logic rxRead = 1'b0;
    logic errorClear = 1'b0;
    logic txReady, txBusy, transmitLine, receiveLine, rxValid;
    logic parityError, overrunError, framingError;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    time prevFall = 0;
    time lastFall = 0;
    time lastRise = 0;
    always #12.5 sys_clk = ~sys_clk;
    urtc_core urtc_core_i (.sys_clk, .rst_n, .clkRun, .powerEnable, .transmitEnable,
        .receiveEnable, .baseClockSelect, .baudDivisor, .parityMode, .txData, .txWrite,
        .txReady, .txBusy, .transmitLine, .receiveLine, .rxData, .rxValid, .rxRead,
        .parityError, .overrunError, .framingError, .errorClear);
    urtc_peer urtc_peer_i (.transmitLine, .receiveLine);
    always @(negedge transmitLine) begin
        prevFall = lastFall;
        lastFall = $time;
    end
    always @(posedge transmitLine) lastRise = $time;
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    function automatic logic [10:0] fr(input urtc_byte_t b);
        return {2'b11, b, 1'b0};
    endfunction
    task automatic setEn(input logic on);
        if (on) powerEnable <= 1'b1;
        else begin
            transmitEnable <= 1'b0;
            receiveEnable <= 1'b0;
        end
        @(posedge sys_clk);
        if (on) begin
            transmitEnable <= 1'b1;
            receiveEnable <= 1'b1;
        end else powerEnable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic ack;
        @(posedge sys_clk);
        rxRead <= 1'b1;
        errorClear <= 1'b1;
        @(posedge sys_clk);
        rxRead <= 1'b0;
        errorClear <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic t_txPair;
        int n0;
        n0 = urtc_peer_i.gotCount;
        // all-ones byte: only start bits fall, so fall to fall is the frame pitch
        txData <= 8'hFF;
        txWrite <= 1'b1;
        repeat (2) @(posedge sys_clk);
        txWrite <= 1'b0;
        repeat (200) @(posedge sys_clk);
        check(lastFall - prevFall == 82 * 25, "queued stop not 2 ticks longer");
        check(urtc_peer_i.gotCount == n0 + 2 && urtc_peer_i.gotByte === 8'hFF, "repeat");
    endtask
    task automatic t_fifo;
        int n;
        int n0;
        n = 0;
        n0 = urtc_peer_i.gotCount;
        txWrite <= 1'b1;
        repeat (40) begin
            @(negedge sys_clk);
            if (txReady === 1'b1) n++;
            @(posedge sys_clk);
            txData <= 8'(n);
        end
        txWrite <= 1'b0;
        check(n == 33, "fifo refusal point");
        for (int i = 0; i < 3000 && txBusy !== 1'b0; i++) @(posedge sys_clk);
        repeat (100) @(posedge sys_clk);
        check(urtc_peer_i.gotCount == n0 + 33 && urtc_peer_i.gotByte === 8'h20, "drain");
    endtask
    task automatic t_rx;
        @(posedge sys_clk);
        urtc_peer_i.send(fr(8'h3C), 10, 195.7);
        check(rxValid === 1'b1 && rxData === 8'h3C, "fast sender");
        @(posedge sys_clk);
        urtc_peer_i.send(fr(8'hC3), 10, 204.3);
        check(rxData === 8'hC3 && overrunError === 1'b1, "slow sender overrun");
        ack();
        check(rxValid === 1'b0 && overrunError === 1'b0, "read and clear");
        // unit that does not own the shared input must ignore it
        @(posedge sys_clk);
        receiveEnable <= 1'b0;
        @(posedge sys_clk);
        urtc_peer_i.send(fr(8'h99), 10, 200.0);
        check(rxValid === 1'b0 && framingError === 1'b0, "rx while disabled");
        @(posedge sys_clk);
        receiveEnable <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic t_frame;
        @(posedge sys_clk);
        urtc_peer_i.send(11'h000, 11, 200.0);
        check(framingError === 1'b1 && rxValid === 1'b1 && rxData === 8'h00, "framing");
        ack();
        repeat (200) @(posedge sys_clk);
        check(rxValid === 1'b0 && framingError === 1'b0, "start on held low");
        @(posedge sys_clk);
        urtc_peer_i.send(11'h7FF, 1, 200.0);
        urtc_peer_i.send(fr(8'h5A), 10, 200.0);
        check(rxValid === 1'b1 && rxData === 8'h5A, "rearm after high");
    endtask
    task automatic t_parity;
        logic pb;
        for (int m = 1; m < 4; m++) begin
            parityMode <= 2'(m);
            pb = (m == 3);
            @(posedge sys_clk);
            urtc_peer_i.send({1'b1, pb, 8'h01, 1'b0}, 11, 200.0);
            check(parityError === 1'b0 && rxData === 8'h01, "good parity");
            @(posedge sys_clk);
            urtc_peer_i.send({1'b1, ~pb, 8'h01, 1'b0}, 11, 200.0);
            check(parityError === 1'b1, "bad parity");
            ack();
        end
        parityMode <= 2'h0;
    endtask
    task automatic t_clkStop;
        txData <= 8'h0F;
        txWrite <= 1'b1;
        @(posedge sys_clk);
        txWrite <= 1'b0;
        repeat (5) @(posedge sys_clk);
        clkRun <= 1'b0;
        repeat (50) @(posedge sys_clk);
        #1;
        check(transmitLine === 1'b0 && txBusy === 1'b1, "freeze");
        @(posedge sys_clk);
        clkRun <= 1'b1;
        setEn(1'b0);
        #1;
        check(transmitLine === 1'b1 && txBusy === 1'b0, "reinit");
    endtask
    task automatic t_rate;
        time w;
        baseClockSelect <= 4'h1;
        baudDivisor <= 8'h05;
        setEn(1'b1);
        txData <= 8'h00;
        txWrite <= 1'b1;
        @(posedge sys_clk);
        txWrite <= 1'b0;
        repeat (250) @(posedge sys_clk);
        w = (lastRise - lastFall) / 25;
        check(w >= 178 && w <= 180, "bit time at m=1 k=5");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(transmitLine === 1'b1 && rxValid === 1'b0 && txReady === 1'b0, "reset");
        setEn(1'b1);
        t_txPair();
        t_fifo();
        t_rx();
        t_frame();
        t_parity();
        t_clkStop();
        t_rate();
        conclude();
    end
endmodule
`default_nettype wire

// File: verification/urtc_peer.sv
// remote serial station: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module urtc_peer (
    input wire logic transmitLine, // from unit
    output logic receiveLine // to unit
);
    int gotCount = 0;
    logic [7:0] gotByte = 8'h00;
    initial receiveLine = 1'b1;
    // bits lsb first, start included; last level is kept so a low line can be held
    task automatic send(input logic [10:0] frame, input int nBits, input real bitNs);
        #3;
        for (int i = 0; i < nBits; i++) begin
            receiveLine = frame[i];
            #(bitNs);
        end
    endtask
    // decodes at nominal 200 ns bits, centre sampling
    always @(negedge transmitLine) begin
        #300;
        for (int i = 0; i < 8; i++) begin
            gotByte[i] = transmitLine;
            #200;
        end
        gotCount++;
    end
endmodule
`default_nettype wire

// File: verilog/urtc_core.sv
// asynchronous serial unit: base clock, transmitter, receiver and error status
`timescale 1ns/1ps
`default_nettype none
`include "urtc_map.svh"
module urtc_core (
    input wire logic sys_clk, // 40 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic clkRun, // unit clock supply present
    input wire logic powerEnable, // power enable bit
    input wire logic transmitEnable, // transmit enable bit
    input wire logic receiveEnable, // receive enable bit
    input wire logic [3:0] baseClockSelect, // m, base clock = main/2^m
    input wire logic [7:0] baudDivisor, // k, 4..255
    input wire logic [1:0] parityMode, // none, zero, odd, even
    input wire urtc_pkg::urtc_byte_t txData, // transmit data register value
    input wire logic txWrite, // write strobe to transmit data register
    output logic txReady, // transmit fifo accepts a write
    output logic txBusy, // frame in progress or queued
    output logic transmitLine, // serial output, idle high
    input wire logic receiveLine, // serial input
    output urtc_pkg::urtc_byte_t rxData, // received byte
    output logic rxValid, // received byte unread
    input wire logic rxRead, // software read of received byte
    output logic parityError, // sticky parity error
    output logic overrunError, // sticky overrun error
    output logic framingError, // sticky framing error
    input wire logic errorClear // clear all error flags
);
    import urtc_pkg::*;

    function automatic logic [`URTC_CNT_W-1:0] bitTicks(input logic [7:0] k);
        logic [7:0] kk;
        kk = (k < `URTC_DIV_MIN) ? `URTC_DIV_MIN : k;
        bitTicks = {1'b0, kk, 1'b0};
    endfunction

    function automatic logic parityOf(input logic [1:0] mode, input urtc_byte_t d);
        parityOf = 1'b0;
        if (mode == `URTC_PAR_ODD) begin
            parityOf = ~(^d);
        end else if (mode == `URTC_PAR_EVEN) begin
            parityOf = ^d;
        end
    endfunction

    // base clock prescaler
    logic [`URTC_PRE_W-1:0] preCnt_q;
    wire cksValid = (baseClockSelect <= `URTC_CKS_MAX);
    wire [`URTC_PRE_W-1:0] preMax = (`URTC_PRE_W'(1) << baseClockSelect) - 1'b1;
    wire running = clkRun && powerEnable;
    wire baseTick = running && cksValid && (preCnt_q == preMax);
    // one bit spans 2k base ticks: divisor clock, then halved
    wire [`URTC_CNT_W-1:0] fullBit = bitTicks(baudDivisor);
    wire [`URTC_CNT_W-1:0] halfBit = {1'b0, fullBit[`URTC_CNT_W-1:1]};
    wire parityOn = (parityMode != `URTC_PAR_NONE);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_q <= '0;
        end else if (clkRun) begin
            if (!powerEnable || baseTick) begin
                preCnt_q <= '0;
            end else begin
                preCnt_q <= preCnt_q + 1'b1;
            end
        end
    end

    // transmit path
    urtc_txState_t txState_q;
    logic [`URTC_CNT_W-1:0] txCnt_q;
    logic [2:0] txIdx_q;
    urtc_byte_t txShift_q;
    logic txLine_q;
    wire fifoValid;
    urtc_byte_t fifoData;
    wire txOn = running && transmitEnable;
    wire txBitEnd = baseTick && (txCnt_q == `URTC_CNT_W'(1));
    wire txStopEnd = (txState_q == TX_STOP) && txBitEnd;
    wire txPop = txOn && fifoValid && ((txState_q == TX_IDLE) || txStopEnd);
    wire txAccept = txWrite && powerEnable && transmitEnable;
    // stop stretch only when another frame is queued behind it
    wire [`URTC_CNT_W-1:0] stopTicks = fifoValid ? fullBit + `URTC_STOP_EXTRA : fullBit;

    urtc_fifo #(
        .WIDTH(`URTC_DATA_W),
        .DEPTH(`URTC_FIFO_DEPTH)
    ) txFifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hold(!clkRun),
        .flush(!(powerEnable && transmitEnable)),
        .inValid(txAccept),
        .inReady(txReady),
        .inData(txData),
        .outValid(fifoValid),
        .outReady(txPop),
        .outData(fifoData)
    );

    assign transmitLine = txLine_q;
    assign txBusy = (txState_q != TX_IDLE) || fifoValid;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txState_q <= TX_IDLE;
            txCnt_q <= '0;
            txIdx_q <= '0;
            txShift_q <= '0;
            txLine_q <= 1'b1;
        end else if (clkRun) begin
            if (!txOn) begin
                txState_q <= TX_IDLE;
                txLine_q <= 1'b1;
            end else if (txPop) begin
                txState_q <= TX_START;
                txShift_q <= fifoData;
                txCnt_q <= fullBit;
                txIdx_q <= '0;
                txLine_q <= 1'b0;
            end else if (txStopEnd) begin
                txState_q <= TX_IDLE;
            end else if (baseTick && txState_q != TX_IDLE) begin
                txCnt_q <= txCnt_q - 1'b1;
                if (txBitEnd) begin
                    txCnt_q <= fullBit;
                    case (txState_q)
                        TX_START: begin
                            txState_q <= TX_DATA;
                            txLine_q <= txShift_q[0];
                        end
                        TX_DATA: begin
                            if (txIdx_q != `URTC_LAST_BIT) begin
                                txIdx_q <= txIdx_q + 1'b1;
                                txLine_q <= txShift_q[txIdx_q + 3'h1];
                            end else if (parityOn) begin
                                txState_q <= TX_PARITY;
                                txLine_q <= parityOf(parityMode, txShift_q);
                            end else begin
                                txState_q <= TX_STOP;
                                txLine_q <= 1'b1;
                                txCnt_q <= stopTicks;
                            end
                        end
                        TX_PARITY: begin
                            txState_q <= TX_STOP;
                            txLine_q <= 1'b1;
                            txCnt_q <= stopTicks;
                        end
                        default: begin
                            txState_q <= TX_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // receive path
    urtc_rxState_t rxState_q;
    logic [`URTC_CNT_W-1:0] rxCnt_q;
    logic [2:0] rxIdx_q;
    urtc_byte_t rxShift_q;
    logic rxParBit_q;
    logic rxArmed_q;
    urtc_byte_t rxData_q;
    logic rxValid_q;
    logic parErr_q;
    logic ovrErr_q;
    logic frmErr_q;
    wire rxOn = running && receiveEnable;
    wire rxLatch = baseTick && (rxCnt_q == `URTC_CNT_W'(1));
    // only an armed line, one seen high, can give a start edge
    wire startSeen = rxOn && rxArmed_q && !receiveLine && (rxState_q == RX_IDLE);
    wire rxDeliver = rxOn && rxLatch && (rxState_q == RX_STOP);
    wire parBad = parityOn && (rxParBit_q != parityOf(parityMode, rxShift_q));

    assign rxData = rxData_q;
    assign rxValid = rxValid_q;
    assign parityError = parErr_q;
    assign overrunError = ovrErr_q;
    assign framingError = frmErr_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxState_q <= RX_IDLE;
            rxCnt_q <= '0;
            rxIdx_q <= '0;
            rxShift_q <= '0;
            rxParBit_q <= 1'b0;
            rxArmed_q <= 1'b0;
        end else if (clkRun) begin
            if (!rxOn) begin
                rxState_q <= RX_IDLE;
                rxArmed_q <= 1'b0;
            end else if (startSeen) begin
                // half bit, k base ticks, to the start centre, with no added margin
                rxState_q <= RX_START;
                rxCnt_q <= halfBit;
                rxIdx_q <= '0;
                rxArmed_q <= 1'b0;
            end else if (rxState_q == RX_IDLE) begin
                rxArmed_q <= rxArmed_q || receiveLine;
            end else if (baseTick) begin
                rxCnt_q <= rxCnt_q - 1'b1;
                if (rxLatch) begin
                    rxCnt_q <= fullBit;
                    case (rxState_q)
                        RX_START: begin
                            rxState_q <= receiveLine ? RX_IDLE : RX_DATA;
                            rxArmed_q <= receiveLine;
                        end
                        RX_DATA: begin
                            rxShift_q[rxIdx_q] <= receiveLine;
                            rxIdx_q <= rxIdx_q + 1'b1;
                            if (rxIdx_q == `URTC_LAST_BIT) begin
                                rxState_q <= parityOn ? RX_PARITY : RX_STOP;
                            end
                        end
                        RX_PARITY: begin
                            rxParBit_q <= receiveLine;
                            rxState_q <= RX_STOP;
                        end
                        default: begin
                            // low stop bit leaves the line unarmed
                            rxState_q <= RX_IDLE;
                            rxArmed_q <= receiveLine;
                        end
                    endcase
                end
            end
        end
    end

    // data register and sticky flags: a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxData_q <= '0;
            rxValid_q <= 1'b0;
            parErr_q <= 1'b0;
            ovrErr_q <= 1'b0;
            frmErr_q <= 1'b0;
        end else if (clkRun) begin
            if (rxRead) begin
                rxValid_q <= 1'b0;
            end
            if (errorClear) begin
                parErr_q <= 1'b0;
                ovrErr_q <= 1'b0;
                frmErr_q <= 1'b0;
            end
            if (rxDeliver) begin
                rxData_q <= rxShift_q;
                rxValid_q <= 1'b1;
                if (rxValid_q && !rxRead) begin
                    ovrErr_q <= 1'b1;
                end
                if (parBad) begin
                    parErr_q <= 1'b1;
                end
                if (!receiveLine) begin
                    frmErr_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: verilog/urtc_fifo.sv
// parameterised valid/ready fifo for the transmit data path
`timescale 1ns/1ps
`default_nettype none
module urtc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic hold, // freeze all state
    input wire logic flush, // drop contents
    input wire logic inValid, // write request
    output logic inReady, // room available
    input wire logic [WIDTH-1:0] inData, // write data
    output logic outValid, // data available
    input wire logic outReady, // consumer takes head
    output logic [WIDTH-1:0] outData // head word
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    wire empty = (wrPtr_q == rdPtr_q);
    wire full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;

    assign inReady = !full && !hold && !flush;
    assign outValid = !empty && !hold && !flush;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (doWrite) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else if (flush && !hold) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verilog/urtc_map.svh
// offsets-free constant map, field widths, reset values and timing for the serial unit
`ifndef URTC_MAP_SVH
`define URTC_MAP_SVH

`define URTC_SYS_CLK_MHZ 40
`define URTC_DATA_W 8
`define URTC_FIFO_DEPTH 32
`define URTC_DIV_RESET 8'hFF
`define URTC_DIV_MIN 8'h04
`define URTC_CKS_MAX 4'hA
`define URTC_PRE_W 10
`define URTC_CNT_W 10
`define URTC_STOP_EXTRA 10'h002
`define URTC_LATCH_MARGIN 2
`define URTC_PAR_NONE 2'h0
`define URTC_PAR_ZERO 2'h1
`define URTC_PAR_ODD 2'h2
`define URTC_PAR_EVEN 2'h3
`define URTC_LAST_BIT 3'h7

`endif

// File: verilog/urtc_pkg.sv
// types shared by the serial unit files
`default_nettype none
package urtc_pkg;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} urtc_txState_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} urtc_rxState_t;
    typedef logic [7:0] urtc_byte_t;
endpackage
`default_nettype wire
